// *** common/paac_pkg.sv ***
package paac_pkg;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [6:0] {
    PAAC_OP_NONE     = 7'h01,
    PAAC_OP_ALIGN1   = 7'h02,
    PAAC_OP_ALIGN2   = 7'h04,
    PAAC_OP_ALIGN3   = 7'h08,
    PAAC_OP_SUPPRESS = 7'h10,
    PAAC_OP_ADDCLIP  = 7'h20,
    PAAC_OP_QUAD     = 7'h40
  } paac_op_t;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0]  PAAC_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  PAAC_OFS_STATUS  = 8'h04;
  localparam logic [7:0]  PAAC_OFS_IRQ_EN  = 8'h08;
  localparam logic [7:0]  PAAC_OFS_IRQ_CLR = 8'h0c;
  localparam logic [7:0]  PAAC_OFS_RESULT  = 8'h10;
  localparam int          PAAC_CTRL_EN_BIT = 0;
  localparam logic [31:0] PAAC_CTRL_RST    = 32'h0000_0001;
  localparam int          PAAC_ST_DONE     = 0;
  localparam int          PAAC_ST_BADENC   = 1;
  localparam int          PAAC_ST_ALNEXC   = 2;
  localparam int          PAAC_ST_SUPPR    = 3;
  localparam int          PAAC_ST_W        = 4;
  localparam logic [1:0]  PAAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PAAC_RESP_SLVERR = 2'h2;
  localparam logic [2:0]  PAAC_PAIR_A      = 3'h0;
  localparam logic [2:0]  PAAC_PAIR_B      = 3'h2;
  localparam logic [7:0]  PAAC_CLIP_MAX    = 8'hff;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    paac_op_t    op;
    logic        high_place;
    logic        reversed;
    logic [2:0]  src0_pair;
    logic [2:0]  src1_pair;
    logic [1:0]  idx0_low;
    logic [1:0]  idx1_low;
    logic [31:0] pa_lo;
    logic [31:0] pa_hi;
    logic [31:0] pb_lo;
    logic [31:0] pb_hi;
  } paac_issue_t;

  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic        via_index;
    logic        word32;
    logic        quad_self;
    logic [31:0] addr;
    logic [31:0] idx_next;
  } paac_mem_t;

  typedef struct packed {
    logic        exc;
    logic        suppressed;
    logic [31:0] addr;
    logic [31:0] idx_next;
  } paac_mem_res_t;

endpackage : paac_pkg

// *** rtl/paac_unit.sv ***
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - Align ops pick bytes from offset 1..3
// - Suppress only indexed 32-bit parallel loads
// - Suppressed load address low bits cleared
// - Index register and post-modify untouched
// - Stores and pointer loads still fault
// - Quad byte ops suppress own faults
// - Suppress and add-clip are long encodings
// - Byte plus halfword clipped to 0..255
// - Halfword sign-extended, full-width clip
// - Low placement into bytes 2 and 0
// - High placement into bytes 3 and 1
// - Only the two fixed pairs valid
// - Index low bits align each pair
// - Code selects bytes n+3..n
// - Default low bytes from lower register
// - Reverse swaps registers within pair
// - Add-clip also suppresses parallel loads
// - Ops coexist with parallel 16-bit slots
module paac_unit (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire paac_pkg::paac_issue_t  issue_in,
  input  wire paac_pkg::paac_mem_t    slot0_in,
  input  wire paac_pkg::paac_mem_t    slot1_in,
  output logic [31:0]                 result_out,
  output logic                        result_valid_out,
  output logic                        bad_enc_out,
  output logic                        long_enc_out,
  output paac_pkg::paac_mem_res_t     slot0_out,
  output paac_pkg::paac_mem_res_t     slot1_out,
  output logic                        irq_out,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0]              result;
    logic                     res_valid;
    logic                     bad_enc;
    logic                     long_enc;
    paac_pkg::paac_mem_res_t  s0;
    paac_pkg::paac_mem_res_t  s1;
    logic [31:0]              ctrl;
    logic [paac_pkg::PAAC_ST_W-1:0] sts;
    logic [paac_pkg::PAAC_ST_W-1:0] ien;
    logic                     irq;
    logic                     aw_have;
    logic [7:0]               aw_addr;
    logic                     w_have;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic                     awready;
    logic                     wready;
  } paac_state_t;

  paac_state_t state_q;
  paac_state_t state_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] pick4(input logic [63:0] pair, input logic [1:0] code);
    pick4 = pair[8*code +: 32];
  endfunction : pick4

  function automatic logic [7:0] clip8(input logic [7:0] b, input logic [15:0] h);
    logic [31:0] sum;
    sum = {{16{h[15]}}, h} + {24'h00_0000, b};
    if (sum[31]) begin
      clip8 = 8'h00;
    end else if (sum > {24'h00_0000, paac_pkg::PAAC_CLIP_MAX}) begin
      clip8 = paac_pkg::PAAC_CLIP_MAX;
    end else begin
      clip8 = sum[7:0];
    end
  endfunction : clip8

  function automatic paac_pkg::paac_mem_res_t slot_eval(input paac_pkg::paac_mem_t m,
                                                        input logic supp);
    logic mis;
    logic ok;
    mis = m.valid & m.word32 & (m.addr[1:0] != 2'h0);
    ok  = (supp & m.is_load & m.via_index) | m.quad_self;
    slot_eval.exc        = mis & ~ok;
    slot_eval.suppressed = mis & ok;
    slot_eval.addr       = (mis & ok) ? {m.addr[31:2], 2'h0} : m.addr;
    slot_eval.idx_next   = m.idx_next;
  endfunction : slot_eval

  // ****************************************
  // Datapath
  // ****************************************
  logic        en;
  logic [63:0] pair_a;
  logic [63:0] pair_b;
  logic [63:0] pair_al;
  logic [31:0] y_al;
  logic [31:0] z_al;
  logic        pairs_ok;
  logic        supp;
  logic [31:0] op_res;
  logic        op_wr;

  assign en       = state_q.ctrl[paac_pkg::PAAC_CTRL_EN_BIT];
  assign pair_a   = issue_in.reversed ? {issue_in.pa_lo, issue_in.pa_hi}
                                      : {issue_in.pa_hi, issue_in.pa_lo};
  assign pair_b   = issue_in.reversed ? {issue_in.pb_lo, issue_in.pb_hi}
                                      : {issue_in.pb_hi, issue_in.pb_lo};
  assign pair_al  = {issue_in.pa_hi, issue_in.pa_lo};
  assign y_al     = pick4(pair_a, issue_in.idx0_low);
  assign z_al     = pick4(pair_b, issue_in.idx1_low);
  assign pairs_ok = (issue_in.src0_pair == paac_pkg::PAAC_PAIR_A) &&
                    (issue_in.src1_pair == paac_pkg::PAAC_PAIR_B);
  assign supp     = issue_in.valid & en &
                    ((issue_in.op == paac_pkg::PAAC_OP_SUPPRESS) ||
                     (issue_in.op == paac_pkg::PAAC_OP_ADDCLIP));

  always_comb begin
    op_res = 32'h0000_0000;
    op_wr  = 1'b0;
    case (issue_in.op)
      paac_pkg::PAAC_OP_ALIGN1: begin
        op_res = pick4(pair_al, 2'h1);
        op_wr  = 1'b1;
      end
      paac_pkg::PAAC_OP_ALIGN2: begin
        op_res = pick4(pair_al, 2'h2);
        op_wr  = 1'b1;
      end
      paac_pkg::PAAC_OP_ALIGN3: begin
        op_res = pick4(pair_al, 2'h3);
        op_wr  = 1'b1;
      end
      paac_pkg::PAAC_OP_ADDCLIP: begin
        op_wr = pairs_ok;
        if (issue_in.high_place) begin
          op_res = {clip8(y_al[15:8], z_al[31:16]), 8'h00,
                    clip8(y_al[7:0], z_al[15:0]), 8'h00};
        end else begin
          op_res = {8'h00, clip8(y_al[15:8], z_al[31:16]),
                    8'h00, clip8(y_al[7:0], z_al[15:0])};
        end
      end
      default: begin
        op_res = 32'h0000_0000;
        op_wr  = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  logic                            aw_take;
  logic                            w_take;
  logic                            ar_take;
  logic                            do_wr;
  logic [paac_pkg::PAAC_ST_W-1:0]  ev;
  logic [paac_pkg::PAAC_ST_W-1:0]  clr;
  logic [paac_pkg::PAAC_ST_W-1:0]  sts_n;

  assign aw_take = s_axi_awvalid & ~state_q.aw_have;
  assign w_take  = s_axi_wvalid & ~state_q.w_have;
  assign ar_take = s_axi_arvalid & state_q.arready;
  assign do_wr   = state_q.aw_have & state_q.w_have & ~state_q.bvalid;

  always_comb begin
    state_d = state_q;
    ev      = '0;
    clr     = '0;
    // Operation issue, slots evaluated every cycle alongside
    state_d.res_valid = 1'b0;
    state_d.bad_enc   = 1'b0;
    state_d.long_enc  = issue_in.valid & ((issue_in.op == paac_pkg::PAAC_OP_SUPPRESS) ||
                        (issue_in.op == paac_pkg::PAAC_OP_ADDCLIP));
    state_d.s0 = slot_eval(slot0_in, supp);
    state_d.s1 = slot_eval(slot1_in, supp);
    if (issue_in.valid && en) begin
      if (op_wr) begin
        state_d.result    = op_res;
        state_d.res_valid = 1'b1;
      end else if (issue_in.op == paac_pkg::PAAC_OP_ADDCLIP) begin
        state_d.bad_enc = 1'b1;
      end
    end
    ev[paac_pkg::PAAC_ST_DONE]   = state_d.res_valid;
    ev[paac_pkg::PAAC_ST_BADENC] = state_d.bad_enc;
    ev[paac_pkg::PAAC_ST_ALNEXC] = state_d.s0.exc | state_d.s1.exc;
    ev[paac_pkg::PAAC_ST_SUPPR]  = state_d.s0.suppressed | state_d.s1.suppressed;
    // Write channel
    if (aw_take) begin
      state_d.aw_have = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      state_d.w_have = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      state_d.bvalid = 1'b1;
      state_d.bresp  = paac_pkg::PAAC_RESP_OKAY;
      case (state_q.aw_addr)
        paac_pkg::PAAC_OFS_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            if (state_q.w_strb[i]) begin
              state_d.ctrl[8*i +: 8] = state_q.w_data[8*i +: 8];
            end
          end
        end
        paac_pkg::PAAC_OFS_IRQ_EN: begin
          if (state_q.w_strb[0]) begin
            state_d.ien = state_q.w_data[paac_pkg::PAAC_ST_W-1:0];
          end
        end
        paac_pkg::PAAC_OFS_IRQ_CLR: begin
          if (state_q.w_strb[0]) begin
            clr = state_q.w_data[paac_pkg::PAAC_ST_W-1:0];
          end
        end
        paac_pkg::PAAC_OFS_STATUS, paac_pkg::PAAC_OFS_RESULT: begin
          state_d.bresp = paac_pkg::PAAC_RESP_OKAY;
        end
        default: begin
          state_d.bresp = paac_pkg::PAAC_RESP_SLVERR;
        end
      endcase
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid  = 1'b0;
      state_d.aw_have = 1'b0;
      state_d.w_have  = 1'b0;
    end
    // Read channel
    if (ar_take) begin
      state_d.arready = 1'b0;
      state_d.rvalid  = 1'b1;
      state_d.rresp   = paac_pkg::PAAC_RESP_OKAY;
      case (s_axi_araddr)
        paac_pkg::PAAC_OFS_CTRL:    state_d.rdata = state_q.ctrl;
        paac_pkg::PAAC_OFS_STATUS:  state_d.rdata = {28'h000_0000, state_q.sts};
        paac_pkg::PAAC_OFS_IRQ_EN:  state_d.rdata = {28'h000_0000, state_q.ien};
        paac_pkg::PAAC_OFS_IRQ_CLR: state_d.rdata = 32'h0000_0000;
        paac_pkg::PAAC_OFS_RESULT:  state_d.rdata = state_q.result;
        default: begin
          state_d.rdata = 32'h0000_0000;
          state_d.rresp = paac_pkg::PAAC_RESP_SLVERR;
        end
      endcase
    end
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid  = 1'b0;
      state_d.arready = 1'b1;
    end
    // Sticky status, set wins over clear
    sts_n       = (state_q.sts & ~clr) | ev;
    state_d.sts = sts_n;
    state_d.irq = |(sts_n & state_d.ien);
    state_d.awready = ~state_d.aw_have;
    state_d.wready  = ~state_d.w_have;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q         <= '0;
      state_q.ctrl    <= paac_pkg::PAAC_CTRL_RST;
      state_q.arready <= 1'b1;
      state_q.awready <= 1'b1;
      state_q.wready  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign result_out       = state_q.result;
  assign result_valid_out = state_q.res_valid;
  assign bad_enc_out      = state_q.bad_enc;
  assign long_enc_out     = state_q.long_enc;
  assign slot0_out        = state_q.s0;
  assign slot1_out        = state_q.s1;
  assign irq_out          = state_q.irq;
  assign s_axi_awready    = state_q.awready;
  assign s_axi_wready     = state_q.wready;
  assign s_axi_bvalid     = state_q.bvalid;
  assign s_axi_bresp      = state_q.bresp;
  assign s_axi_arready    = state_q.arready;
  assign s_axi_rvalid     = state_q.rvalid;
  assign s_axi_rdata      = state_q.rdata;
  assign s_axi_rresp      = state_q.rresp;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_align1_issued;
    issue_in.valid && en && issue_in.op == paac_pkg::PAAC_OP_ALIGN1;
  endsequence

  sequence s_addclip_bad;
    issue_in.valid && en && issue_in.op == paac_pkg::PAAC_OP_ADDCLIP && !pairs_ok;
  endsequence

  property p_align1;
    @(posedge clk_in) disable iff (reset_in)
    s_align1_issued |=> result_valid_out && result_out == $past(pair_al[39:8]);
  endproperty
  a_align1: assert property (p_align1) else $error("align one wrong");

  property p_supp_addr;
    @(posedge clk_in) disable iff (reset_in)
    (supp && slot0_in.valid && slot0_in.is_load && slot0_in.via_index && slot0_in.word32)
      |=> !slot0_out.exc && slot0_out.addr[1:0] == 2'h0;
  endproperty
  a_supp_addr: assert property (p_supp_addr) else $error("suppressed load wrong");

  property p_store_faults;
    @(posedge clk_in) disable iff (reset_in)
    (slot1_in.valid && !slot1_in.is_load && !slot1_in.quad_self && slot1_in.word32 &&
     slot1_in.addr[1:0] != 2'h0) |=> slot1_out.exc && slot1_out.addr == $past(slot1_in.addr);
  endproperty
  a_store_faults: assert property (p_store_faults) else $error("store fault lost");

  property p_idx_pass;
    @(posedge clk_in) disable iff (reset_in)
    1'b1 |=> slot0_out.idx_next == $past(slot0_in.idx_next);
  endproperty
  a_idx_pass: assert property (p_idx_pass) else $error("index changed");

  property p_long;
    @(posedge clk_in) disable iff (reset_in)
    (issue_in.valid && issue_in.op == paac_pkg::PAAC_OP_SUPPRESS) |=> long_enc_out;
  endproperty
  a_long: assert property (p_long) else $error("long encoding missed");

  property p_bad_pair;
    @(posedge clk_in) disable iff (reset_in)
    s_addclip_bad |=> bad_enc_out && !result_valid_out && $stable(result_out);
  endproperty
  a_bad_pair: assert property (p_bad_pair) else $error("bad pair accepted");

  property p_lo_zero;
    @(posedge clk_in) disable iff (reset_in)
    (issue_in.valid && en && issue_in.op == paac_pkg::PAAC_OP_ADDCLIP && pairs_ok &&
     !issue_in.high_place) |=> result_out[31:24] == 8'h00 && result_out[15:8] == 8'h00;
  endproperty
  a_lo_zero: assert property (p_lo_zero) else $error("low placement spill");

  property p_hi_zero;
    @(posedge clk_in) disable iff (reset_in)
    (issue_in.valid && en && issue_in.op == paac_pkg::PAAC_OP_ADDCLIP && pairs_ok &&
     issue_in.high_place) |=> result_out[23:16] == 8'h00 && result_out[7:0] == 8'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high placement spill");

  property p_clip_neg;
    @(posedge clk_in) disable iff (reset_in)
    (issue_in.valid && en && issue_in.op == paac_pkg::PAAC_OP_ADDCLIP && pairs_ok &&
     !issue_in.high_place && z_al[15] && z_al[14:8] != 7'h7f) |=> result_out[7:0] == 8'h00;
  endproperty
  a_clip_neg: assert property (p_clip_neg) else $error("negative not clipped");

  property p_irq;
    @(posedge clk_in) disable iff (reset_in)
    1'b1 |-> irq_out == |(state_q.sts & state_q.ien);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule : paac_unit

// *** verif/paac_core_model.sv ***
`timescale 1ns/10ps
module paac_core_model (
  input  wire logic             clk_in,
  output paac_pkg::paac_issue_t issue_out,
  output paac_pkg::paac_mem_t   slot0_out,
  output paac_pkg::paac_mem_t   slot1_out
);
  // ****************************************
  // Bundle drive, one edge per call
  // ****************************************
  initial begin
    issue_out = '0;
    slot0_out = '0;
    slot1_out = '0;
  end

  task automatic step(input paac_pkg::paac_issue_t i, input paac_pkg::paac_mem_t s0, input paac_pkg::paac_mem_t s1);
    @(posedge clk_in);
    issue_out <= i;
    slot0_out <= s0;
    slot1_out <= s1;
  endtask : step

  // Released operands flip so stale data never passes
  task automatic idle();
    @(posedge clk_in);
    issue_out.valid <= 1'b0;
    issue_out.pa_lo <= ~issue_out.pa_lo;
    issue_out.pa_hi <= ~issue_out.pa_hi;
    issue_out.pb_lo <= ~issue_out.pb_lo;
    issue_out.pb_hi <= ~issue_out.pb_hi;
    slot0_out.valid <= 1'b0;
    slot1_out.valid <= 1'b0;
    slot0_out.addr  <= ~slot0_out.addr;
    slot1_out.addr  <= ~slot1_out.addr;
  endtask : idle
endmodule : paac_core_model

// *** verif/test_pixel_align_add_clip_unit.sv ***
`timescale 1ns/10ps
module test_pixel_align_add_clip_unit;
  // ****************************************
  // Signals
  // ****************************************
  logic                    clk_in = 1'b0;
  logic                    reset_in = 1'b1;
  paac_pkg::paac_issue_t   issue;
  paac_pkg::paac_mem_t     slot0, slot1;
  paac_pkg::paac_mem_res_t so0, so1;
  logic [31:0]             result, wdata = '0, rdata, pal, pah, pbl, pbh, last, d;
  logic                    res_v, bad_enc, long_enc, irq, awready, wready, bvalid, arready, rvalid;
  logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]              awaddr = '0, araddr = '0;
  logic [3:0]              wstrb = '0;
  logic [1:0]              bresp, rresp, r;
  int                      bad_count = 0, n_tests = 0;
  localparam paac_pkg::paac_mem_t NOMEM = '0;

  always #25 clk_in = ~clk_in;

  paac_unit dut (
    .clk_in(clk_in), .reset_in(reset_in), .issue_in(issue), .slot0_in(slot0), .slot1_in(slot1),
    .result_out(result), .result_valid_out(res_v), .bad_enc_out(bad_enc), .long_enc_out(long_enc),
    .slot0_out(so0), .slot1_out(so1), .irq_out(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  paac_core_model core (.clk_in(clk_in), .issue_out(issue), .slot0_out(slot0), .slot1_out(slot1));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    if (n >= 100) bad_count++;
    chk("write response", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    rd(a);
    chk(what, e, d);
  endtask : rd_chk

  task automatic do_op(input paac_pkg::paac_op_t o, input logic hi, rev, input logic [2:0] p0,
                       input logic [1:0] i0, i1, input paac_pkg::paac_mem_t s0, s1);
    core.step('{valid: 1'b1, op: o, high_place: hi, reversed: rev, src0_pair: p0,
                src1_pair: paac_pkg::PAAC_PAIR_B, idx0_low: i0, idx1_low: i1, pa_lo: pal,
                pa_hi: pah, pb_lo: pbl, pb_hi: pbh}, s0, s1);
    core.idle();
    #1;
  endtask : do_op

  task automatic sp(input paac_pkg::paac_op_t o, input paac_pkg::paac_mem_t s0, s1);
    do_op(o, 1'b0, 1'b0, paac_pkg::PAAC_PAIR_A, 2'h0, 2'h0, s0, s1);
  endtask : sp

  function automatic paac_pkg::paac_mem_t mk(input logic ld, ix, qd, input logic [31:0] a);
    mk = '{valid: 1'b1, is_load: ld, via_index: ix, word32: 1'b1, quad_self: qd, addr: a,
           idx_next: 32'h0000_0200};
  endfunction : mk

  function automatic logic [7:0] clip(input int s);
    return s < 0 ? 8'h00 : (s > 32'sh0000_00ff ? 8'hff : 8'(s));
  endfunction : clip

  function automatic logic [31:0] addclip(input logic [63:0] a, b, input logic [1:0] i0, i1, input logic hi);
    logic [31:0] y, z;
    logic [7:0]  c0, c1;
    y = 32'(a >> (8 * i0));
    z = 32'(b >> (8 * i1));
    c0 = clip(int'(y[7:0]) + int'($signed(z[15:0])));
    c1 = clip(int'(y[15:8]) + int'($signed(z[31:16])));
    return hi ? {c1, 8'h00, c0, 8'h00} : {8'h00, c1, 8'h00, c0};
  endfunction : addclip

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    rd_chk(paac_pkg::PAAC_OFS_CTRL, paac_pkg::PAAC_CTRL_RST, "ctrl reset");
    rd_chk(paac_pkg::PAAC_OFS_STATUS, 32'h0000_0000, "status reset");
    rd_chk(paac_pkg::PAAC_OFS_IRQ_EN, 32'h0000_0000, "irq enable reset");
    rd_chk(paac_pkg::PAAC_OFS_RESULT, 32'h0000_0000, "result reset");
    rd(8'h20);
    chk("unmapped read response", {30'h0, paac_pkg::PAAC_RESP_SLVERR}, {30'h0, r});
    pal = 32'hbeef_dead;
    pah = 32'habcd_1234;
    do_op(paac_pkg::PAAC_OP_ALIGN1, 1'b0, 1'b0, paac_pkg::PAAC_PAIR_A, 2'h0, 2'h0, NOMEM, NOMEM);
    chk("align one", 32'h34be_efde, result);
    chk("align flags", 32'h0000_0001, {long_enc, res_v});
    do_op(paac_pkg::PAAC_OP_ALIGN2, 1'b0, 1'b0, paac_pkg::PAAC_PAIR_A, 2'h0, 2'h0, NOMEM, NOMEM);
    chk("align two", 32'h1234_beef, result);
    do_op(paac_pkg::PAAC_OP_ALIGN3, 1'b0, 1'b0, paac_pkg::PAAC_PAIR_A, 2'h0, 2'h0, NOMEM, NOMEM);
    chk("align three", 32'hcd12_34be, result);
    pal = 32'h1020_30f0;
    pah = 32'h80ff_7f01;
    pbl = 32'hff9c_0064;
    pbh = 32'h7fff_8000;
    for (int k = 0; k < 16; k++) begin
      do_op(paac_pkg::PAAC_OP_ADDCLIP, k[0], k[1], paac_pkg::PAAC_PAIR_A, k[3:2], ~k[3:2], NOMEM, NOMEM);
      last = addclip(k[1] ? {pal, pah} : {pah, pal}, k[1] ? {pbl, pbh} : {pbh, pbl}, k[3:2], ~k[3:2], k[0]);
      chk("add clip result", last, result);
      chk("add clip flags", 32'h0000_0003, {long_enc, res_v});
    end
    sp(paac_pkg::PAAC_OP_SUPPRESS, mk(1'b1, 1'b1, 1'b0, 32'h0000_0103), mk(1'b0, 1'b1, 1'b0, 32'h0000_0107));
    chk("suppressed load exc", 32'h0000_0001, {so0.exc, so0.suppressed});
    chk("suppressed load addr", 32'h0000_0100, so0.addr);
    chk("suppressed load index", 32'h0000_0200, so0.idx_next);
    chk("store exc", 32'h8000_0107, {so1.exc, so1.addr[30:0]});
    chk("suppress long", 32'h0000_0002, {long_enc, res_v});
    sp(paac_pkg::PAAC_OP_SUPPRESS, mk(1'b1, 1'b0, 1'b0, 32'h0000_0106), NOMEM);
    chk("pointer load exc", 32'h0000_0001, so0.exc);
    sp(paac_pkg::PAAC_OP_NONE, mk(1'b1, 1'b1, 1'b0, 32'h0000_0103), NOMEM);
    chk("unsuppressed load exc", 32'h0000_0001, so0.exc);
    sp(paac_pkg::PAAC_OP_ADDCLIP, mk(1'b1, 1'b1, 1'b0, 32'h0000_0101), NOMEM);
    last = addclip({pah, pal}, {pbh, pbl}, 2'h0, 2'h0, 1'b0);
    chk("add clip load", 32'h0000_0100, {so0.exc, so0.addr[30:0]});
    sp(paac_pkg::PAAC_OP_QUAD, mk(1'b1, 1'b1, 1'b1, 32'h0000_0102), NOMEM);
    chk("quad access exc", 32'h0000_0000, so0.exc);
    do_op(paac_pkg::PAAC_OP_ADDCLIP, 1'b0, 1'b0, 3'h4, 2'h1, 2'h2, NOMEM, NOMEM);
    chk("bad pair flags", 32'h0000_0002, {bad_enc, res_v});
    chk("bad pair result", last, result);
    wr(paac_pkg::PAAC_OFS_CTRL, 32'h0000_0000, paac_pkg::PAAC_RESP_OKAY);
    do_op(paac_pkg::PAAC_OP_ALIGN1, 1'b0, 1'b0, paac_pkg::PAAC_PAIR_A, 2'h0, 2'h0, NOMEM, NOMEM);
    chk("disabled result valid", 32'h0000_0000, res_v);
    wr(paac_pkg::PAAC_OFS_CTRL, 32'h0000_0001, paac_pkg::PAAC_RESP_OKAY);
    rd_chk(paac_pkg::PAAC_OFS_STATUS, 32'h0000_000f, "status events");
    chk("masked irq", 32'h0000_0000, irq);
    wr(paac_pkg::PAAC_OFS_IRQ_EN, 32'h0000_0002, paac_pkg::PAAC_RESP_OKAY);
    repeat (2) @(posedge clk_in);
    #1;
    chk("enabled irq", 32'h0000_0001, irq);
    wr(paac_pkg::PAAC_OFS_IRQ_CLR, 32'h0000_0002, paac_pkg::PAAC_RESP_OKAY);
    repeat (2) @(posedge clk_in);
    #1;
    chk("cleared irq", 32'h0000_0000, irq);
    wr(paac_pkg::PAAC_OFS_STATUS, 32'h0000_0000, paac_pkg::PAAC_RESP_OKAY);
    rd_chk(paac_pkg::PAAC_OFS_STATUS, 32'h0000_000d, "status after clear");
    rd_chk(paac_pkg::PAAC_OFS_IRQ_CLR, 32'h0000_0000, "clear reads zero");
    rd_chk(paac_pkg::PAAC_OFS_IRQ_EN, 32'h0000_0002, "irq enable");
    rd_chk(paac_pkg::PAAC_OFS_RESULT, last, "result register");
    wr(8'h20, 32'h0000_0000, paac_pkg::PAAC_RESP_SLVERR);
    stop_test();
  end

  initial begin
    repeat (3000) @(posedge clk_in);
    bad_count++;
    stop_test();
  end
endmodule : test_pixel_align_add_clip_unit
